/* File: rtl/tlv_irq_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tlv_irq_ctrl
    import tlv_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] bit_addr,
    input wire logic bit_wr,
    input wire logic bit_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic supply_monitor_request,
    input wire logic watchdog_request,
    input wire logic ext0_request,
    input wire logic converter_request,
    input wire logic timer0_overflow_request,
    input wire logic ext1_request,
    input wire logic timer1_overflow_request,
    input wire logic serial_if_request,
    input wire logic uart_request,
    input wire logic timer2_request,
    input wire logic interval_request,
    input wire logic cpu_boundary,
    input wire logic cpu_reti,
    output logic push_pc,
    output logic load_pc,
    output logic [15:0] pc_vector,
    output logic [NSRC-1:0] src_ack,
    output logic active_hi,
    output logic active_lo
);
    localparam int IW = 4;

    logic [7:0] enable_reg, level_reg, secondary_reg;
    logic [NSRC-1:0] req, en, lvl, elig_hi, elig_lo;
    logic found_hi, found_lo;
    logic [IW-1:0] idx_hi, idx_lo;

    tlv_state_e state, next_state;
    logic [IW-1:0] sel_idx, next_sel_idx;
    logic sel_hi, next_sel_hi;
    logic next_push_pc, next_load_pc, next_active_hi, next_active_lo;
    logic take;
    logic [15:0] next_pc_vector, vec_of_sel;
    logic [NSRC-1:0] next_src_ack;

    tlv_regs u_regs (
        .clk(clk),
        .rst_n(rst_n),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata),
        .bit_addr(bit_addr),
        .bit_wr(bit_wr),
        .bit_wdata(bit_wdata),
        .sfr_rdata(sfr_rdata),
        .enable_reg(enable_reg),
        .interrupt_priority_select(level_reg),
        .secondary_irq_enable_priority(secondary_reg)
    );

    // sources packed by polling rank; watchdog sits at rank 1, just ahead of ext0 at rank 2
    always_comb begin
        req = '0;
        req[SRC_SUPPLY] = supply_monitor_request;
        req[SRC_WDOG] = watchdog_request;
        req[SRC_EXT0] = ext0_request;
        req[SRC_CONV] = converter_request;
        req[SRC_TMR0] = timer0_overflow_request;
        req[SRC_EXT1] = ext1_request;
        req[SRC_TMR1] = timer1_overflow_request;
        req[SRC_SERIAL] = serial_if_request;
        req[SRC_UART] = uart_request;
        req[SRC_TMR2] = timer2_request;
        req[SRC_INTERVAL] = interval_request;
    end

    always_comb begin
        en = '0;
        lvl = '0;
        en[SRC_SUPPLY] = secondary_reg[BIT_SUPPLY_EN];
        en[SRC_SERIAL] = secondary_reg[BIT_SERIAL_EN];
        en[SRC_INTERVAL] = secondary_reg[BIT_INTERVAL_EN];
        en[SRC_WDOG] = 1'b1;
        en[SRC_EXT0] = enable_reg[BIT_EXT0];
        en[SRC_TMR0] = enable_reg[BIT_TMR0];
        en[SRC_EXT1] = enable_reg[BIT_EXT1];
        en[SRC_TMR1] = enable_reg[BIT_TMR1];
        en[SRC_UART] = enable_reg[BIT_UART];
        en[SRC_TMR2] = enable_reg[BIT_TMR2];
        en[SRC_CONV] = enable_reg[BIT_CONV];
        lvl[SRC_SUPPLY] = secondary_reg[BIT_SUPPLY_LVL];
        lvl[SRC_SERIAL] = secondary_reg[BIT_SERIAL_LVL];
        lvl[SRC_INTERVAL] = secondary_reg[BIT_INTERVAL_LVL];
        lvl[SRC_WDOG] = WDOG_LEVEL;
        lvl[SRC_EXT0] = level_reg[BIT_EXT0];
        lvl[SRC_TMR0] = level_reg[BIT_TMR0];
        lvl[SRC_EXT1] = level_reg[BIT_EXT1];
        lvl[SRC_TMR1] = level_reg[BIT_TMR1];
        lvl[SRC_UART] = level_reg[BIT_UART];
        lvl[SRC_TMR2] = level_reg[BIT_TMR2];
        lvl[SRC_CONV] = level_reg[BIT_CONV];
    end

    // a high routine in service blocks both levels; a low routine blocks only low
    always_comb begin
        elig_hi = '0;
        elig_lo = '0;
        if (enable_reg[BIT_GLOBAL_EN]) begin
            if (!active_hi) begin
                elig_hi = req & en & lvl;
            end
            if (!active_hi && !active_lo) begin
                elig_lo = req & en & ~lvl;
            end
        end
    end

    tlv_pick #(.N(NSRC), .IW(IW)) u_pick_hi (
        .req(elig_hi),
        .found(found_hi),
        .idx(idx_hi)
    );

    tlv_pick #(.N(NSRC), .IW(IW)) u_pick_lo (
        .req(elig_lo),
        .found(found_lo),
        .idx(idx_lo)
    );

    always_comb begin
        case (sel_idx)
            4'h0: vec_of_sel = VEC_SUPPLY;
            4'h1: vec_of_sel = VEC_WDOG;
            4'h2: vec_of_sel = VEC_EXT0;
            4'h3: vec_of_sel = VEC_CONV;
            4'h4: vec_of_sel = VEC_TMR0;
            4'h5: vec_of_sel = VEC_EXT1;
            4'h6: vec_of_sel = VEC_TMR1;
            4'h7: vec_of_sel = VEC_SERIAL;
            4'h8: vec_of_sel = VEC_UART;
            4'h9: vec_of_sel = VEC_TMR2;
            4'ha: vec_of_sel = VEC_INTERVAL;
            default: vec_of_sel = 16'h0000;
        endcase
    end

    // a take needs an instruction boundary and an idle sequencer
    assign take = (state == TLV_IDLE) && cpu_boundary && (found_hi || found_lo);

    // arbitration is frozen from the take until the vector load, so the push and load refer to one source
    always_comb begin
        next_state = state;
        next_sel_idx = sel_idx;
        next_sel_hi = sel_hi;
        case (state)
            TLV_IDLE: begin
                if (take) begin
                    next_state = TLV_PUSH;
                    next_sel_hi = found_hi;
                    next_sel_idx = found_hi ? idx_hi : idx_lo;
                end
            end
            TLV_PUSH: begin
                next_state = TLV_LOAD;
            end
            TLV_LOAD: begin
                next_state = TLV_IDLE;
            end
            default: begin
                next_state = TLV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= TLV_IDLE;
            sel_idx <= '0;
            sel_hi <= 1'b0;
        end else begin
            state <= next_state;
            sel_idx <= next_sel_idx;
            sel_hi <= next_sel_hi;
        end
    end

    // the push leads the load by one cycle, so the old count is stacked before the jump
    always_comb begin
        next_push_pc = 1'b0;
        next_load_pc = 1'b0;
        next_pc_vector = pc_vector;
        next_src_ack = '0;
        if (take) begin
            next_push_pc = 1'b1;
        end
        if (state == TLV_PUSH) begin
            next_load_pc = 1'b1;
            next_pc_vector = vec_of_sel;
            next_src_ack[sel_idx] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            push_pc <= 1'b0;
            load_pc <= 1'b0;
            pc_vector <= 16'h0000;
            src_ack <= '0;
        end else begin
            push_pc <= next_push_pc;
            load_pc <= next_load_pc;
            pc_vector <= next_pc_vector;
            src_ack <= next_src_ack;
        end
    end

    // entering service wins over a return seen in the same cycle
    always_comb begin
        next_active_hi = active_hi;
        next_active_lo = active_lo;
        if (cpu_reti) begin
            if (active_hi) begin
                next_active_hi = 1'b0;
            end else begin
                next_active_lo = 1'b0;
            end
        end
        if (state == TLV_LOAD) begin
            if (sel_hi) begin
                next_active_hi = 1'b1;
            end else begin
                next_active_lo = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_hi <= 1'b0;
            active_lo <= 1'b0;
        end else begin
            active_hi <= next_active_hi;
            active_lo <= next_active_lo;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/tlv_pkg.sv */
package tlv_pkg;

    localparam int NSRC = 11;

    localparam logic [7:0] ADDR_ENABLE = 8'ha8;
    localparam logic [7:0] ADDR_LEVEL = 8'hb8;
    localparam logic [7:0] ADDR_SECONDARY = 8'ha9;

    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_LEVEL = 8'h00;
    localparam logic [7:0] RST_SECONDARY = 8'ha0;

    localparam logic [7:0] LEVEL_RD_MASK = 8'h7f;

    // bit address = {byte_addr[7:3], bit}; only the two words on an 8-aligned address take bit operations
    localparam logic [4:0] BITBLK_ENABLE = 5'h15;
    localparam logic [4:0] BITBLK_LEVEL = 5'h17;

    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_CONV = 6;
    localparam int BIT_TMR2 = 5;
    localparam int BIT_UART = 4;
    localparam int BIT_TMR1 = 3;
    localparam int BIT_EXT1 = 2;
    localparam int BIT_TMR0 = 1;
    localparam int BIT_EXT0 = 0;

    localparam int BIT_INTERVAL_LVL = 6;
    localparam int BIT_SUPPLY_LVL = 5;
    localparam int BIT_SERIAL_LVL = 4;
    localparam int BIT_INTERVAL_EN = 2;
    localparam int BIT_SUPPLY_EN = 1;
    localparam int BIT_SERIAL_EN = 0;

    // source index is the polling rank, 0 first
    localparam int SRC_SUPPLY = 0;
    localparam int SRC_WDOG = 1;
    localparam int SRC_EXT0 = 2;
    localparam int SRC_CONV = 3;
    localparam int SRC_TMR0 = 4;
    localparam int SRC_EXT1 = 5;
    localparam int SRC_TMR1 = 6;
    localparam int SRC_SERIAL = 7;
    localparam int SRC_UART = 8;
    localparam int SRC_TMR2 = 9;
    localparam int SRC_INTERVAL = 10;

    // the watchdog has neither enable nor level bit; only the global enable gates it, and it is always high level
    localparam logic WDOG_LEVEL = 1'b1;

    localparam logic [15:0] VEC_SUPPLY = 16'h0043;
    localparam logic [15:0] VEC_WDOG = 16'h005b;
    localparam logic [15:0] VEC_EXT0 = 16'h0003;
    localparam logic [15:0] VEC_CONV = 16'h0033;
    localparam logic [15:0] VEC_TMR0 = 16'h000b;
    localparam logic [15:0] VEC_EXT1 = 16'h0013;
    localparam logic [15:0] VEC_TMR1 = 16'h001b;
    localparam logic [15:0] VEC_SERIAL = 16'h003b;
    localparam logic [15:0] VEC_UART = 16'h0023;
    localparam logic [15:0] VEC_TMR2 = 16'h002b;
    localparam logic [15:0] VEC_INTERVAL = 16'h0053;

    typedef enum logic [1:0] {
        TLV_IDLE = 2'b00,
        TLV_PUSH = 2'b01,
        TLV_LOAD = 2'b10
    } tlv_state_e;

endpackage

/* File: rtl/tlv_pick.sv */
`timescale 1ns/1ps
`default_nettype none
module tlv_pick
    import tlv_pkg::*;
#(
    parameter int N = NSRC,
    parameter int IW = 4
) (
    input wire logic [N-1:0] req,
    output logic found,
    output logic [IW-1:0] idx
);
    logic [N:0] seen;
    logic [N-1:0] grant;

    assign seen[0] = 1'b0;

    // lowest index wins: fixed polling order within one level
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_rank
            assign grant[g] = req[g] & ~seen[g];
            assign seen[g+1] = seen[g] | req[g];
        end
    endgenerate

    assign found = seen[N];

    always_comb begin
        idx = '0;
        for (int i = 0; i < N; i++) begin
            if (grant[i]) begin
                idx = IW'(i);
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/tlv_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tlv_regs
    import tlv_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] bit_addr,
    input wire logic bit_wr,
    input wire logic bit_wdata,
    output logic [7:0] sfr_rdata,
    output logic [7:0] enable_reg,
    output logic [7:0] interrupt_priority_select,
    output logic [7:0] secondary_irq_enable_priority
);
    logic [7:0] next_enable, next_level, next_secondary, next_rdata;

    always_comb begin
        next_enable = enable_reg;
        next_level = interrupt_priority_select;
        next_secondary = secondary_irq_enable_priority;
        next_rdata = sfr_rdata;
        if (sfr_wr) begin
            case (sfr_addr)
                ADDR_ENABLE: next_enable = sfr_wdata;
                ADDR_LEVEL: next_level = sfr_wdata;
                ADDR_SECONDARY: next_secondary = sfr_wdata;
                default: ;
            endcase
        end
        // no bit address decodes to the secondary word, so bit instructions never touch it
        if (bit_wr) begin
            if (bit_addr[7:3] == BITBLK_ENABLE) begin
                next_enable[bit_addr[2:0]] = bit_wdata;
            end else if (bit_addr[7:3] == BITBLK_LEVEL) begin
                next_level[bit_addr[2:0]] = bit_wdata;
            end
        end
        if (sfr_rd) begin
            case (sfr_addr)
                ADDR_ENABLE: next_rdata = enable_reg;
                ADDR_LEVEL: next_rdata = interrupt_priority_select & LEVEL_RD_MASK;
                ADDR_SECONDARY: next_rdata = secondary_irq_enable_priority;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg <= RST_ENABLE;
            interrupt_priority_select <= RST_LEVEL;
            secondary_irq_enable_priority <= RST_SECONDARY;
            sfr_rdata <= 8'h00;
        end else begin
            enable_reg <= next_enable;
            interrupt_priority_select <= next_level;
            secondary_irq_enable_priority <= next_secondary;
            sfr_rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tlv_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// core sequencer stand-in: unless held, boundary every cycle, or every other cycle when slow
module tlv_cpu_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hold,
    input wire logic slow,
    input wire logic reti_req,
    output logic cpu_boundary,
    output logic cpu_reti
);
    logic ph;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph <= 1'b0;
        end else begin
            ph <= ~ph;
        end
    end
    assign cpu_boundary = !hold && (!slow || ph);
    // the bench only asks for a return while a routine is in service
    assign cpu_reti = reti_req;
endmodule
`default_nettype wire

/* File: tb/tlv_irq_ctrl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module tlv_irq_ctrl_assertions
    import tlv_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] bit_addr,
    input wire logic bit_wr,
    input wire logic bit_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic cpu_boundary,
    input wire logic cpu_reti,
    input wire logic push_pc,
    input wire logic load_pc,
    input wire logic [15:0] pc_vector,
    input wire logic [NSRC-1:0] src_ack,
    input wire logic active_hi,
    input wire logic active_lo
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    localparam logic [15:0] VT [NSRC] = '{VEC_SUPPLY, VEC_WDOG, VEC_EXT0, VEC_CONV, VEC_TMR0, VEC_EXT1,
        VEC_TMR1, VEC_SERIAL, VEC_UART, VEC_TMR2, VEC_INTERVAL};
    // shadow of the global enable, tracked from byte and bit writes
    logic ge;
    logic next_ge;
    always_comb begin
        next_ge = ge;
        if (sfr_wr && sfr_addr == ADDR_ENABLE) begin
            next_ge = sfr_wdata[BIT_GLOBAL_EN];
        end
        if (bit_wr && bit_addr == {BITBLK_ENABLE, 3'h7}) begin
            next_ge = bit_wdata;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ge <= 1'b0;
        end else begin
            ge <= next_ge;
        end
    end
    sequence take_seq;
        push_pc ##1 load_pc;
    endsequence
    sequence enter_seq;
        load_pc ##1 (active_hi || active_lo);
    endsequence
    chk_push_then_load: assert property (push_pc |-> take_seq)
        else $error("load did not follow push");
    chk_load_needs_push: assert property (load_pc |-> $past(push_pc))
        else $error("load without push");
    chk_global_gate: assert property (push_pc |-> $past(ge) && $past(cpu_boundary))
        else $error("take while globally disabled");
    chk_same_level_block: assert property (push_pc |-> !$past(active_hi))
        else $error("take while high routine active");
    chk_ack_one_hot: assert property ((load_pc || src_ack != '0) |-> load_pc && $onehot(src_ack))
        else $error("ack not one-hot with load");
    for (genvar i = 0; i < NSRC; i++) begin : g_vec
        chk_vector_map: assert property (load_pc && src_ack[i] |-> pc_vector == VT[i])
            else $error("wrong vector");
    end
    chk_vector_hold: assert property (!load_pc |-> $stable(pc_vector))
        else $error("vector moved without load");
    chk_enter_service: assert property (load_pc |-> enter_seq)
        else $error("no active level after load");
    chk_preempt_high: assert property (push_pc && active_lo |-> ##2 active_hi)
        else $error("low routine pre-empted by non-high");
    chk_reti_clear: assert property (cpu_reti && active_hi && !load_pc |=> !active_hi)
        else $error("return left high active");
    chk_level_bit7: assert property (sfr_rd && sfr_addr == ADDR_LEVEL |=> !sfr_rdata[7])
        else $error("level bit 7 read as one");
endmodule
`default_nettype wire

/* File: tb/test_two_level_irq_priority_vector.sv */
`timescale 1ns/1ps
`default_nettype none
module test_two_level_irq_priority_vector import tlv_pkg::*;;
    logic clk;
    logic rst_n;
    logic [7:0] sfr_addr, sfr_wdata, bit_addr, sfr_rdata, en, lv, sc, r;
    logic sfr_wr, sfr_rd, bit_wr, bit_wdata, cpu_boundary, cpu_reti;
    logic push_pc, load_pc, active_hi, active_lo, hold, slow, reti_req, ahi, alo, pp;
    logic [15:0] pc_vector;
    logic [NSRC-1:0] src_ack, rq, lvv;
    int fail_count, comparisons, seed, n, x;
    logic [15:0] vt [NSRC] = '{VEC_SUPPLY, VEC_WDOG, VEC_EXT0, VEC_CONV, VEC_TMR0, VEC_EXT1,
        VEC_TMR1, VEC_SERIAL, VEC_UART, VEC_TMR2, VEC_INTERVAL};

    tlv_irq_ctrl tlv_irq_ctrl_inst (.clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .bit_addr,
        .bit_wr, .bit_wdata, .sfr_rdata, .supply_monitor_request(rq[0]), .watchdog_request(rq[1]),
        .ext0_request(rq[2]), .converter_request(rq[3]), .timer0_overflow_request(rq[4]),
        .ext1_request(rq[5]), .timer1_overflow_request(rq[6]), .serial_if_request(rq[7]),
        .uart_request(rq[8]), .timer2_request(rq[9]), .interval_request(rq[10]), .cpu_boundary,
        .cpu_reti, .push_pc, .load_pc, .pc_vector, .src_ack, .active_hi, .active_lo);
    tlv_cpu_model tlv_cpu_model_inst (.clk, .rst_n, .hold, .slow, .reti_req, .cpu_boundary, .cpu_reti);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic complete_run();
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick();
        sfr_wr = 1'b0;
        tick();
    endtask
    task automatic bw(input logic [7:0] a, input logic v);
        bit_addr = a;
        bit_wdata = v;
        bit_wr = 1'b1;
        tick();
        bit_wr = 1'b0;
        tick();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        sfr_addr = a;
        sfr_rd = 1'b1;
        tick();
        sfr_rd = 1'b0;
        tick();
        chk({8'h00, sfr_rdata}, {8'h00, e});
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (2) tick();
        rst_n = 1'b1;
        ahi = 1'b0;
        alo = 1'b0;
    endtask
    // reference arbiter: index of the source the block should take, -1 if none
    function automatic int pick();
        logic [NSRC-1:0] el, h;
        lvv = {sc[6], lv[5], lv[4], sc[4], lv[3], lv[2], lv[1], lv[6], lv[0], 1'b1, sc[5]};
        el = rq & {sc[2], en[5], en[4], sc[0], en[3], en[2], en[1], en[6], en[0], 1'b1, sc[1]};
        el = el & {NSRC{en[7]}};
        h = el & lvv & {NSRC{!ahi}};
        if (h == '0) begin
            h = el & ~lvv & {NSRC{!ahi && !alo}};
        end
        for (int i = 0; i < NSRC; i++) begin
            if (h[i]) begin
                return i;
            end
        end
        return -1;
    endfunction

    initial begin
        {rst_n, sfr_addr, sfr_wdata, bit_addr, sfr_wr, sfr_rd, bit_wr, bit_wdata} = '0;
        {slow, reti_req, rq, fail_count, comparisons} = '0;
        hold = 1'b1;
        seed = 68105;
        do_reset();
        rd(ADDR_ENABLE, RST_ENABLE);
        rd(ADDR_LEVEL, RST_LEVEL);
        rd(ADDR_SECONDARY, RST_SECONDARY);
        rd(8'hb9, 8'h00);
        for (int k = 0; k < 40; k++) begin
            en = 8'($random(seed));
            lv = 8'($random(seed));
            sc = 8'($random(seed)) & 8'hf7;
            r = 8'($random(seed));
            wr(ADDR_ENABLE, en);
            wr(ADDR_LEVEL, lv);
            wr(ADDR_SECONDARY, sc);
            bw({BITBLK_ENABLE, 3'h7}, r[0]);
            en[BIT_GLOBAL_EN] = r[0];
            bw({BITBLK_LEVEL, r[5:3]}, r[6]);
            lv[r[5:3]] = r[6];
            rd(ADDR_ENABLE, en);
            rd(ADDR_LEVEL, lv & LEVEL_RD_MASK);
            rd(ADDR_SECONDARY, sc);
            rq = 11'($random(seed));
            x = pick();
            slow = r[1];
            hold = 1'b0;
            n = 0;
            pp = 1'b0;
            // pp keeps the push strobe seen one cycle before the current sample
            while (load_pc !== 1'b1 && n < 12) begin
                pp = push_pc;
                tick();
                n++;
            end
            hold = 1'b1;
            rq = '0;
            if (x < 0) begin
                chk({15'h0000, load_pc}, 16'h0000);
                chk({15'h0000, pp}, 16'h0000);
            end else begin
                chk({15'h0000, load_pc}, 16'h0001);
                chk({15'h0000, pp}, 16'h0001);
                chk(pc_vector, vt[x]);
                chk({5'h00, src_ack}, 16'h0001 << x);
                ahi = ahi | lvv[x];
                alo = alo | ~lvv[x];
            end
            // return only once the entered level is visible, so set and clear never collide
            if (r[2] && (ahi || alo)) begin
                tick();
                reti_req = 1'b1;
                tick();
                reti_req = 1'b0;
                if (ahi) begin
                    ahi = 1'b0;
                end else begin
                    alo = 1'b0;
                end
            end
            tick();
            chk({14'h0000, active_hi, active_lo}, {14'h0000, ahi, alo});
        end
        do_reset();
        rd(ADDR_SECONDARY, RST_SECONDARY);
        complete_run();
    end
    initial begin
        #1000000;
        fail_count++;
        complete_run();
    end
endmodule
bind tlv_irq_ctrl tlv_irq_ctrl_assertions tlv_irq_ctrl_assertions_inst (.clk, .rst_n, .sfr_addr, .sfr_wr,
    .sfr_rd, .sfr_wdata, .bit_addr, .bit_wr, .bit_wdata, .sfr_rdata, .cpu_boundary, .cpu_reti, .push_pc,
    .load_pc, .pc_vector, .src_ack, .active_hi, .active_lo);
`default_nettype wire
